// File: core/monitor_pkg.sv
package monitor_pkg;
	// register byte offsets on the wishbone slave
	localparam logic [3:0] OFS_CTRL = 4'h0;
	localparam logic [3:0] OFS_THRESH = 4'h4;
	localparam logic [3:0] OFS_STATUS = 4'h8;
	localparam logic [3:0] OFS_TELEM = 4'hC;
	// control register fields
	localparam int CTRL_VCONN_REQ = 0;
	localparam int CTRL_SHORT_EN = 1;
	localparam int CTRL_OCP_SEL_LO = 2;
	localparam int CTRL_BLEED_REQ = 4;
	localparam int CTRL_FAST_TRANS = 5;
	localparam int CTRL_CV_LOAD = 6;
	localparam int CTRL_NTC_EN = 7;
	localparam logic [7:0] CTRL_RESET = 8'h82;
	// threshold register fields: die hysteresis, ntc trip code, auto-restart mv
	localparam int THR_NTC_LO = 8;
	localparam int THR_AR_LO = 16;
	localparam logic [31:0] THR_RESET = 32'h0BB8_4064;
	// status fields: sticky events low, live state from bit 8
	localparam int ST_OCP = 0;
	localparam int ST_SHORT = 1;
	localparam int ST_NTC = 2;
	localparam int ST_DIE = 3;
	localparam int ST_LIVE_LO = 8;
	localparam int TEL_IOUT_LO = 16;
	// pin synchroniser slots
	localparam int PIN_RAIL = 0;
	localparam int PIN_SHORT = 1;
	localparam int PIN_BPP_RST = 2;
	localparam int PIN_UV = 3;
	// protection figures
	localparam logic [7:0] DIE_OT_LIMIT_C = 8'h7D;
	localparam logic [7:0] OCP_LIMIT_0_MA = 8'h23;
	localparam logic [7:0] OCP_LIMIT_1_MA = 8'h28;
	localparam logic [7:0] OCP_LIMIT_2_MA = 8'h2D;
	localparam logic [2:0] SHORT_CHECK_CYCLES = 3'h4;
	// telemetry figures
	localparam logic [15:0] OUTPUT_SENSE_PIN_BAND1_MV = 16'h1C20;
	localparam logic [15:0] OUTPUT_SENSE_PIN_BAND2_MV = 16'h2710;
	localparam logic [15:0] OUTPUT_SENSE_PIN_STEP1_MV = 16'h0014;
	localparam logic [15:0] OUTPUT_SENSE_PIN_STEP2_MV = 16'h0032;
	localparam logic [15:0] OUTPUT_SENSE_PIN_STEP3_MV = 16'h0064;
	localparam logic [7:0] IOUT_FULL_CODE = 8'h80;
	localparam int AVG_DEPTH = 16;
	localparam int CLK_HZ = 200000000;
	localparam int UPDATE_PERIOD_MS = 100;
	localparam int UPDATE_PERIOD_CYCLES = UPDATE_PERIOD_MS * (CLK_HZ / 1000);
	typedef enum {VC_IDLE, VC_SHORT_CHECK, VC_SOFT_START, VC_ON, VC_FAULT} vconn_state_t;
endpackage

// File: core/tel_if.sv
`timescale 1ns/1ps
`default_nettype none
interface tel_if;
	logic sample_valid;
	logic run;
	logic [15:0] output_sense_pin_mv;
	logic [7:0] iout_code;
	logic [15:0] avg_output_sense_pin;
	logic [7:0] avg_iout;
	logic [15:0] rep_output_sense_pin;
	logic [7:0] rep_iout;
	modport feed(output sample_valid, run, output_sense_pin_mv, iout_code,
		input avg_output_sense_pin, avg_iout, rep_output_sense_pin, rep_iout);
	modport engine(input sample_valid, run, output_sense_pin_mv, iout_code,
		output avg_output_sense_pin, avg_iout, rep_output_sense_pin, rep_iout);
endinterface
`default_nettype wire

// File: core/telemetry_avg.sv
`timescale 1ns/1ps
`default_nettype none
module telemetry_avg import monitor_pkg::*; #(
	parameter int unsigned UPDATE_CYCLES = UPDATE_PERIOD_CYCLES
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// samples in, averages and reports out
	tel_if.engine t
);
	logic [15:0] vhist_q [AVG_DEPTH];
	logic [7:0] ihist_q [AVG_DEPTH];
	logic [19:0] vsum_q;
	logic [11:0] isum_q;
	logic [31:0] tick_cnt_q;
	logic tick;
	logic [15:0] rep_output_sense_pin_q;
	logic [7:0] rep_iout_q;

	// report granularity coarsens as the output voltage climbs
	function automatic logic [15:0] quantise(input logic [15:0] mv);
		logic [15:0] step;
		step = (mv < OUTPUT_SENSE_PIN_BAND1_MV) ? OUTPUT_SENSE_PIN_STEP1_MV :
			(mv < OUTPUT_SENSE_PIN_BAND2_MV) ? OUTPUT_SENSE_PIN_STEP2_MV : OUTPUT_SENSE_PIN_STEP3_MV;
		return mv - (mv % step);
	endfunction

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			vsum_q <= 20'h00000;
			isum_q <= 12'h000;
			for (int i = 0; i < AVG_DEPTH; i++) begin
				vhist_q[i] <= 16'h0000;
				ihist_q[i] <= 8'h00;
			end
		end else if (t.run && t.sample_valid) begin
			// running sum drops the oldest of the last sixteen samples
			vsum_q <= vsum_q + 20'(t.output_sense_pin_mv) - 20'(vhist_q[AVG_DEPTH-1]); // RQ12
			isum_q <= isum_q + 12'(t.iout_code) - 12'(ihist_q[AVG_DEPTH-1]); // RQ12
			vhist_q[0] <= t.output_sense_pin_mv;
			ihist_q[0] <= t.iout_code;
			for (int i = 1; i < AVG_DEPTH; i++) begin
				vhist_q[i] <= vhist_q[i-1];
				ihist_q[i] <= ihist_q[i-1];
			end
		end
	end

	assign t.avg_output_sense_pin = vsum_q[19:4];
	assign t.avg_iout = isum_q[11:4];

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			tick_cnt_q <= 32'h00000000;
		end else if (!t.run || tick) begin
			tick_cnt_q <= 32'h00000000;
		end else begin
			tick_cnt_q <= tick_cnt_q + 32'h00000001;
		end
	end
	assign tick = tick_cnt_q == 32'(UPDATE_CYCLES - 1);

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			rep_output_sense_pin_q <= 16'h0000;
			rep_iout_q <= 8'h00;
		end else if (tick) begin
			rep_output_sense_pin_q <= quantise(t.avg_output_sense_pin); // RQ10 RQ13
			rep_iout_q <= t.avg_iout; // RQ11 RQ13
		end
	end
	assign t.rep_output_sense_pin = rep_output_sense_pin_q;
	assign t.rep_iout = rep_iout_q;

	default clocking @(posedge ref_clk); endclocking
	default disable iff (reset);
	chk_report_period: assert property ($changed(rep_output_sense_pin_q) |-> $past(tick)) // RQ13
		else $error("voltage report changed off the update tick");
	chk_avg_window: assert property (t.run && t.sample_valid
		|=> vsum_q == $past(vsum_q) + 20'($past(t.output_sense_pin_mv)) - 20'($past(vhist_q[15]))) // RQ12
		else $error("rolling sum not over sixteen samples");
endmodule
`default_nettype wire

// File: core/secondary_monitor.sv
// Register access over Wishbone and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// Contract
// RQ1: die above 125 C turns the output bleeder off.
// RQ2: bleeder stays off until die cools below programmable hysteresis level.
// RQ3: cable supply current mirror enabled only after its soft start ends.
// RQ4: firmware picks 35, 40 or 45 mA; current compared to it.
// RQ5: current above limit raises fault and opens cable supply switch.
// RQ6: CC line short below 18 ohm checked before soft start; fault, switch off.
// RQ7: firmware enables or disables the short check.
// RQ8: thermistor code past firmware threshold issues supply shutdown command.
// RQ9: shutdown latch clears only on primary supply reset or input undervoltage.
// RQ10: voltage report steps 20, 50 or 100 mV by band.
// RQ11: current report is relative; 128 means full constant-current threshold.
// RQ12: regulation uses rolling average of last 16 voltage and current samples.
// RQ13: reported voltage and current refreshed every 100 ms.
// RQ14: logic shuts down while the controller supply rail is too low.
// RQ15: output below auto-restart threshold enters auto-restart until load drops.
// RQ16: above 32 mV sense regulate pulses for fixed current, else constant voltage.
// RQ17: in continuous conduction, rectifier off just before requesting a cycle.
// RQ18: firmware option shortens low-to-high output voltage transitions.
// RQ19: firmware option reduces current ripple for constant-voltage loads only.
// RQ20: each detected fault held in readable status until firmware clears it.
module secondary_monitor import monitor_pkg::*; #(
	parameter int unsigned UPDATE_CYCLES = UPDATE_PERIOD_CYCLES
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [3:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// asynchronous pin levels
	input wire logic controller_supply_rail_ok,
	input wire logic cc_load_short,
	input wire logic primary_supply_reset_level,
	input wire logic input_undervoltage_threshold,
	// measurements on ref_clk
	input wire logic [7:0] die_temp_c,
	input wire logic [7:0] ntc_code,
	input wire logic [7:0] vconn_current_ma,
	input wire logic vconn_soft_start_done,
	input wire logic sample_valid,
	input wire logic [15:0] output_sense_pin_mv,
	input wire logic [7:0] iout_code,
	input wire logic ccm_active,
	input wire logic cycle_request,
	// protection outputs
	output logic bleeder_enable,
	output logic vconn_switch_on,
	output logic vconn_sense_enable,
	output logic vconn_fault,
	output logic supply_shutdown_command,
	// regulation outputs
	output logic cc_regulation,
	output logic ripple_reduce,
	output logic fast_transient,
	output logic auto_restart,
	output logic sr_gate_off,
	output logic primary_cycle_request,
	// telemetry
	output logic [15:0] output_sense_pin_report,
	output logic [7:0] iout_report
);
	logic [3:0] pin_raw, pin_s1_q, pin_s2_q, pin_s3_q, pin_f_q;
	logic rail_up, short_f, clear_latch;
	logic [7:0] ctrl_q;
	logic [31:0] thr_q;
	logic [3:0] sticky_q, events;
	logic ack_q;
	logic [31:0] dat_q;
	logic wr_ctrl, wr_thr, wr_status;
	vconn_state_t vc_q, vc_d;
	logic [2:0] chk_cnt_q;
	logic over_limit, short_seen;
	logic die_block_q, die_block_d, bleeder_q;
	logic ntc_trip, shutdown_q;
	logic cc_q, ripple_q, fast_q, ar_q;
	logic sr_off_q, req_pend_q, req_q;
	logic sw_q, sense_q, fault_q;
	tel_if tel();

	function automatic logic [31:0] lane_mask(input logic [3:0] sel);
		return {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
	endfunction

	function automatic logic [7:0] ocp_limit(input logic [1:0] pick);
		case (pick)
			2'h0: return OCP_LIMIT_0_MA;
			2'h1: return OCP_LIMIT_1_MA;
			default: return OCP_LIMIT_2_MA;
		endcase
	endfunction

	// three-stage pin synchroniser; a level counts once stages two and three agree
	assign pin_raw = {input_undervoltage_threshold, primary_supply_reset_level,
		cc_load_short, controller_supply_rail_ok};
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			pin_s1_q <= 4'h0;
			pin_s2_q <= 4'h0;
			pin_s3_q <= 4'h0;
			pin_f_q <= 4'h0;
		end else begin
			pin_s1_q <= pin_raw;
			pin_s2_q <= pin_s1_q;
			pin_s3_q <= pin_s2_q;
			pin_f_q <= (pin_s2_q & pin_s3_q) | (pin_f_q & (pin_s2_q ^ pin_s3_q));
		end
	end
	assign rail_up = pin_f_q[PIN_RAIL]; // RQ14
	assign short_f = pin_f_q[PIN_SHORT];
	assign clear_latch = pin_f_q[PIN_BPP_RST] | pin_f_q[PIN_UV];

	// wishbone: ack one cycle after the request, writes land on the acked edge
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= cyc_i & stb_i & ~ack_q;
		end
	end
	assign ack_o = ack_q;
	assign wr_ctrl = cyc_i & stb_i & we_i & ack_q & (adr_i == OFS_CTRL);
	assign wr_thr = cyc_i & stb_i & we_i & ack_q & (adr_i == OFS_THRESH);
	assign wr_status = cyc_i & stb_i & we_i & ack_q & (adr_i == OFS_STATUS);

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			dat_q <= 32'h00000000;
		end else if (cyc_i && stb_i && !ack_q) begin
			case (adr_i)
				OFS_CTRL: dat_q <= {24'h000000, ctrl_q};
				OFS_THRESH: dat_q <= thr_q;
				OFS_STATUS: dat_q <= {18'h00000, rail_up, cc_q, ar_q, sw_q, shutdown_q,
					die_block_q, 4'h0, sticky_q}; // RQ20
				OFS_TELEM: dat_q <= {8'h00, tel.rep_iout, tel.rep_output_sense_pin};
				default: dat_q <= 32'h00000000;
			endcase
		end
	end
	assign dat_o = dat_q;

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			ctrl_q <= CTRL_RESET;
		end else if (wr_ctrl) begin
			// short check enable and limit choice live here
			ctrl_q <= (ctrl_q & ~8'(lane_mask(sel_i))) | (dat_i[7:0] & 8'(lane_mask(sel_i))); // RQ7
		end
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			thr_q <= THR_RESET;
		end else if (wr_thr) begin
			thr_q <= (thr_q & ~lane_mask(sel_i)) | (dat_i & lane_mask(sel_i));
		end
	end

	// sticky faults: write one to clear, a new event in the same cycle wins
	assign events[ST_OCP] = over_limit;
	assign events[ST_SHORT] = short_seen;
	assign events[ST_NTC] = ntc_trip & ~shutdown_q;
	assign events[ST_DIE] = die_block_d & ~die_block_q;
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			sticky_q <= 4'h0;
		end else begin
			sticky_q <= (sticky_q & ~(wr_status ? dat_i[3:0] & {4{sel_i[0]}} : 4'h0)) | events; // RQ20
		end
	end

	// die over-temperature lockout with hysteresis
	always_comb begin
		die_block_d = die_block_q;
		if (die_temp_c > DIE_OT_LIMIT_C) begin
			die_block_d = 1'b1; // RQ1
		end else if (die_temp_c < thr_q[7:0]) begin
			die_block_d = 1'b0; // RQ2
		end
	end
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			die_block_q <= 1'b0;
			bleeder_q <= 1'b0;
		end else begin
			die_block_q <= die_block_d;
			bleeder_q <= rail_up & ctrl_q[CTRL_BLEED_REQ] & ~die_block_d; // RQ1 RQ2
		end
	end
	assign bleeder_enable = bleeder_q;

	// cable supply sequencing: short check, soft start, sensed on-state
	assign over_limit = (vc_q == VC_ON) &&
		(vconn_current_ma > ocp_limit(ctrl_q[CTRL_OCP_SEL_LO +: 2])); // RQ4
	// the CC comparator trips below 18 ohm; only trusted before soft start
	assign short_seen = (vc_q == VC_SHORT_CHECK) && ctrl_q[CTRL_SHORT_EN] && short_f; // RQ6

	always_comb begin
		vc_d = vc_q;
		case (vc_q)
			VC_IDLE: begin
				if (ctrl_q[CTRL_VCONN_REQ]) begin
					vc_d = ctrl_q[CTRL_SHORT_EN] ? VC_SHORT_CHECK : VC_SOFT_START; // RQ7
				end
			end
			VC_SHORT_CHECK: begin
				if (short_seen) begin
					vc_d = VC_FAULT; // RQ6
				end else if (!ctrl_q[CTRL_VCONN_REQ]) begin
					vc_d = VC_IDLE;
				end else if (chk_cnt_q == SHORT_CHECK_CYCLES - 3'h1) begin
					vc_d = VC_SOFT_START;
				end
			end
			VC_SOFT_START: begin
				if (!ctrl_q[CTRL_VCONN_REQ]) begin
					vc_d = VC_IDLE;
				end else if (vconn_soft_start_done) begin
					vc_d = VC_ON; // RQ3
				end
			end
			VC_ON: begin
				if (over_limit) begin
					vc_d = VC_FAULT; // RQ5
				end else if (!ctrl_q[CTRL_VCONN_REQ]) begin
					vc_d = VC_IDLE;
				end
			end
			VC_FAULT: begin
				// held off until firmware withdraws the request or the rail drops
				if (!ctrl_q[CTRL_VCONN_REQ]) begin
					vc_d = VC_IDLE;
				end
			end
			default: vc_d = VC_IDLE;
		endcase
		if (!rail_up) begin
			vc_d = VC_IDLE; // RQ14
		end
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			vc_q <= VC_IDLE;
			chk_cnt_q <= 3'h0;
			sw_q <= 1'b0;
			sense_q <= 1'b0;
			fault_q <= 1'b0;
		end else begin
			vc_q <= vc_d;
			chk_cnt_q <= (vc_q == VC_SHORT_CHECK) ? chk_cnt_q + 3'h1 : 3'h0;
			sw_q <= (vc_d == VC_SOFT_START) || (vc_d == VC_ON); // RQ5 RQ6
			sense_q <= vc_d == VC_ON; // RQ3
			fault_q <= vc_d == VC_FAULT; // RQ5 RQ6
		end
	end
	assign vconn_switch_on = sw_q;
	assign vconn_sense_enable = sense_q;
	assign vconn_fault = fault_q;

	// connector thermistor: lower voltage means hotter
	assign ntc_trip = rail_up && ctrl_q[CTRL_NTC_EN] && (ntc_code < thr_q[THR_NTC_LO +: 8]);
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			shutdown_q <= 1'b0;
		end else if (clear_latch) begin
			shutdown_q <= 1'b0; // RQ9
		end else if (ntc_trip) begin
			shutdown_q <= 1'b1; // RQ8
		end
	end
	assign supply_shutdown_command = shutdown_q;

	// telemetry and averaging run only while the rail is up
	assign tel.sample_valid = sample_valid;
	assign tel.run = rail_up; // RQ14
	assign tel.output_sense_pin_mv = output_sense_pin_mv;
	assign tel.iout_code = iout_code;
	telemetry_avg #(.UPDATE_CYCLES(UPDATE_CYCLES)) u_tel (
		.ref_clk(ref_clk),
		.reset(reset),
		.t(tel)
	);
	assign output_sense_pin_report = tel.rep_output_sense_pin;
	assign iout_report = tel.rep_iout;

	// regulation mode from averaged current; full code equals the 32 mV threshold
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			cc_q <= 1'b0;
			ripple_q <= 1'b0;
			fast_q <= 1'b0;
		end else begin
			cc_q <= rail_up && (tel.avg_iout >= IOUT_FULL_CODE); // RQ16
			ripple_q <= rail_up && ctrl_q[CTRL_CV_LOAD] && (tel.avg_iout >= IOUT_FULL_CODE); // RQ19
			fast_q <= rail_up && ctrl_q[CTRL_FAST_TRANS]; // RQ18
		end
	end
	assign cc_regulation = cc_q;
	assign ripple_reduce = ripple_q;
	assign fast_transient = fast_q;

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			ar_q <= 1'b0;
		end else if (!rail_up || (ar_q && !cc_q)) begin
			ar_q <= 1'b0; // RQ15
		end else if (cc_q && (tel.avg_output_sense_pin < thr_q[THR_AR_LO +: 16])) begin
			ar_q <= 1'b1; // RQ15
		end
	end
	assign auto_restart = ar_q;

	// request is delayed a cycle so the rectifier is already off when it leaves
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			sr_off_q <= 1'b0;
			req_pend_q <= 1'b0;
			req_q <= 1'b0;
		end else begin
			sr_off_q <= rail_up & ~ar_q & ccm_active & cycle_request; // RQ17
			req_pend_q <= rail_up & ~ar_q & cycle_request;
			// a request caught as the rail drops must not leave after it
			req_q <= req_pend_q & rail_up; // RQ17 RQ14
		end
	end
	assign sr_gate_off = sr_off_q;
	assign primary_cycle_request = req_q;

	default clocking @(posedge ref_clk); endclocking
	default disable iff (reset);
	sequence s_short_found;
		vc_q == VC_SHORT_CHECK && ctrl_q[CTRL_SHORT_EN] && short_f;
	endsequence
	sequence s_held_off;
		(!sw_q && fault_q) [*2];
	endsequence
	chk_die_lockout: assert property (die_temp_c > DIE_OT_LIMIT_C |=> !bleeder_q) // RQ1
		else $error("bleeder on above die limit");
	chk_die_hyst: assert property (die_block_q && die_temp_c >= thr_q[7:0] |=> !bleeder_q) // RQ2
		else $error("bleeder re-enabled above hysteresis");
	chk_sense_after_ss: assert property ($rose(sense_q) |-> $past(vconn_soft_start_done)) // RQ3
		else $error("current sense before soft start end");
	chk_ocp_trip: assert property (over_limit && rail_up |=> fault_q && !sw_q) // RQ4 RQ5
		else $error("over-current did not open switch");
	chk_short_block: assert property ((s_short_found and (rail_up && ctrl_q[CTRL_VCONN_REQ]))
		|=> s_held_off) // RQ6
		else $error("short did not keep switch off");
	chk_ntc_latch: assert property (shutdown_q && !clear_latch |=> shutdown_q) // RQ9
		else $error("shutdown latch released without reset cause");
	chk_rail_down: assert property (!rail_up |=> !sw_q && !bleeder_q && !req_q) // RQ14
		else $error("outputs active with rail down");
	chk_sr_before_req: assert property (req_pend_q && rail_up && $past(ccm_active)
		|-> sr_off_q ##1 req_q) // RQ17
		else $error("request without rectifier off first");
	chk_sticky_hold: assert property (sticky_q[ST_OCP] && !wr_status |=> sticky_q[ST_OCP]) // RQ20
		else $error("fault flag lost without clear");
endmodule
`default_nettype wire

// File: bench/vconn_switch_model.sv
`timescale 1ns/1ps
`default_nettype none
module vconn_switch_model (
	// clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// switch control from the monitor
	input wire logic switch_on,
	input wire logic sense_enable,
	// bench commands
	input wire logic slow,
	input wire logic [7:0] load_ma,
	// switch status back to the monitor
	output logic soft_start_done,
	output logic [7:0] current_ma
);
	logic [5:0] ramp_q;

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			ramp_q <= 6'h00;
		end else if (!switch_on) begin
			ramp_q <= 6'h00;
		end else if (ramp_q != 6'h3F) begin
			ramp_q <= ramp_q + 6'h01;
		end
	end

	// soft start ends only after the gate has ramped for a while
	assign soft_start_done = switch_on && (ramp_q >= (slow ? 6'h1E : 6'h02));
	// an unsensed mirror carries no meaning; show a moving pattern, not a stale value
	assign current_ma = sense_enable ? load_ma : ({ramp_q, 2'h2} ^ load_ma);
endmodule
`default_nettype wire

// File: bench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
	import monitor_pkg::*;
	localparam int UPD = 64;
	logic ref_clk, reset, cyc_i, stb_i, we_i, ack_o, rail_ok, cc_short, bpp_rst, uv;
	logic soft_done, sample_valid, ccm_active, cycle_request, slow, ar;
	logic [3:0] adr_i, sel_i;
	logic [31:0] dat_i, dat_o, rd;
	logic [7:0] die_temp_c, ntc_code, cur_ma, iout_code, load_ma, iout_report, lim;
	logic [15:0] output_sense_pin_mv, output_sense_pin_report, lfsr_q;
	logic bleeder_enable, vconn_switch_on, vconn_sense_enable, vconn_fault, supply_shutdown_command;
	logic cc_regulation, ripple_reduce, fast_transient, auto_restart, sr_gate_off, primary_cycle_request;
	logic [15:0] vt[5];
	logic [7:0] it[5];
	logic [7:0] dt[4];
	logic be[4];
	int fails, checks;

	secondary_monitor #(.UPDATE_CYCLES(UPD)) secondary_monitor_inst (.ref_clk(ref_clk), .reset(reset),
		.cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
		.dat_o(dat_o), .ack_o(ack_o), .controller_supply_rail_ok(rail_ok), .cc_load_short(cc_short),
		.primary_supply_reset_level(bpp_rst), .input_undervoltage_threshold(uv),
		.die_temp_c(die_temp_c), .ntc_code(ntc_code), .vconn_current_ma(cur_ma),
		.vconn_soft_start_done(soft_done), .sample_valid(sample_valid), .output_sense_pin_mv(output_sense_pin_mv),
		.iout_code(iout_code), .ccm_active(ccm_active), .cycle_request(cycle_request),
		.bleeder_enable(bleeder_enable), .vconn_switch_on(vconn_switch_on),
		.vconn_sense_enable(vconn_sense_enable), .vconn_fault(vconn_fault),
		.supply_shutdown_command(supply_shutdown_command), .cc_regulation(cc_regulation),
		.ripple_reduce(ripple_reduce), .fast_transient(fast_transient), .auto_restart(auto_restart),
		.sr_gate_off(sr_gate_off), .primary_cycle_request(primary_cycle_request),
		.output_sense_pin_report(output_sense_pin_report), .iout_report(iout_report));

	vconn_switch_model vconn_switch_model_inst (.ref_clk(ref_clk), .reset(reset),
		.switch_on(vconn_switch_on), .sense_enable(vconn_sense_enable), .slow(slow),
		.load_ma(load_ma), .soft_start_done(soft_done), .current_ma(cur_ma));

	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end

	function automatic logic [15:0] lfsr_next(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	function automatic logic [15:0] quant(input logic [15:0] mv);
		if (mv < OUTPUT_SENSE_PIN_BAND1_MV) return mv - mv % OUTPUT_SENSE_PIN_STEP1_MV;
		if (mv < OUTPUT_SENSE_PIN_BAND2_MV) return mv - mv % OUTPUT_SENSE_PIN_STEP2_MV;
		return mv - mv % OUTPUT_SENSE_PIN_STEP3_MV;
	endfunction

	function automatic logic watch(input int w);
		case (w)
			0: return vconn_switch_on;
			default: return vconn_sense_enable;
		endcase
	endfunction

	task automatic close_out();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			fails++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
	endtask

	task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
		int n;
		@(posedge ref_clk);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= d;
		sel_i <= 4'hF;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (ack_o !== 1'b1 && n < 16);
		if (n >= 16) begin
			fails++;
			close_out();
		end
		rd = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		we_i <= 1'b0;
	endtask

	// bounded wait of 200 cycles; a miss is not failed here
	task automatic wait_for(input int w);
		int n;
		n = 0;
		while (watch(w) !== 1'b1 && n < 200) begin
			@(posedge ref_clk);
			n++;
		end
	endtask

	task automatic feed(input logic [15:0] v, input logic [7:0] i);
		repeat (16) begin
			@(posedge ref_clk);
			sample_valid <= 1'b1;
			output_sense_pin_mv <= v;
			iout_code <= i;
			@(posedge ref_clk);
			sample_valid <= 1'b0;
			output_sense_pin_mv <= ~v;
		end
	endtask

	initial begin
		repeat (100000) @(posedge ref_clk);
		fails++;
		close_out();
	end

	initial begin
		{reset, rail_ok} = 2'b11;
		{cyc_i, stb_i, we_i, cc_short, bpp_rst, uv, sample_valid, ccm_active, cycle_request, slow} = '0;
		{adr_i, sel_i, dat_i, load_ma, iout_code, output_sense_pin_mv} = '0;
		die_temp_c = 8'h19;
		ntc_code = 8'hC0;
		lfsr_q = 16'h0001;
		fails = 0;
		checks = 0;
		cyc(12);
		reset <= 1'b0;
		cyc(10);
		wb(0, OFS_CTRL, 32'h0);
		chk("ctrl_reset", {24'h0, CTRL_RESET}, rd);
		wb(0, OFS_THRESH, 32'h0);
		chk("thresh_reset", THR_RESET, rd);
		wb(1, 4'h2, 32'hFFFF_FFFF);
		wb(0, 4'h2, 32'h0);
		chk("unmapped_read", 32'h0, rd);
		wb(0, OFS_CTRL, 32'h0);
		chk("ctrl_after_unmapped", {24'h0, CTRL_RESET}, rd);
		$display("register test done");

		dt = '{8'h7D, 8'h7E, 8'h64, 8'h63};
		be = '{1'b1, 1'b0, 1'b0, 1'b1};
		wb(1, OFS_CTRL, 32'h92);
		for (int k = 0; k < 4; k++) begin
			die_temp_c <= dt[k];
			cyc(4);
			chk("bleeder_enable", be[k], bleeder_enable);
		end
		wb(0, OFS_STATUS, 32'h0);
		chk("status_die", 1, rd[ST_DIE]);
		wb(1, OFS_STATUS, 32'h8);
		$display("die temperature test done");

		for (int s = 0; s < 3; s++) begin
			lim = (s == 0) ? OCP_LIMIT_0_MA : (s == 1) ? OCP_LIMIT_1_MA : OCP_LIMIT_2_MA;
			slow <= ~s[0];
			load_ma <= lim;
			wb(1, OFS_CTRL, {24'h0, 8'h83 | 8'(s << 2)});
			wait_for(0);
			chk("sense_in_soft_start", 0, vconn_sense_enable);
			wait_for(1);
			chk("vconn_sense_enable", 1, vconn_sense_enable);
			cyc(4);
			chk("fault_at_limit", 0, vconn_fault);
			load_ma <= lim + 8'h01;
			cyc(3);
			chk("vconn_fault", 1, vconn_fault);
			chk("switch_after_ocp", 0, vconn_switch_on);
			wb(1, OFS_CTRL, 32'h82);
			wb(0, OFS_STATUS, 32'h0);
			chk("status_ocp", 1, rd[ST_OCP]);
			wb(1, OFS_STATUS, 32'h1);
			wb(0, OFS_STATUS, 32'h0);
			chk("status_ocp_cleared", 0, rd[ST_OCP]);
			load_ma <= 8'h00;
		end
		$display("over-current test done");

		cc_short <= 1'b1;
		wb(1, OFS_CTRL, 32'h83);
		cyc(14);
		chk("short_fault", 1, vconn_fault);
		chk("short_switch", 0, vconn_switch_on);
		wb(0, OFS_STATUS, 32'h0);
		chk("status_short", 1, rd[ST_SHORT]);
		wb(1, OFS_CTRL, 32'h82);
		wb(1, OFS_CTRL, 32'h81);
		wait_for(0);
		chk("short_check_off", 1, vconn_switch_on);
		cc_short <= 1'b0;
		wb(1, OFS_CTRL, 32'h82);
		wb(1, OFS_STATUS, 32'h2);
		wb(0, OFS_STATUS, 32'h0);
		chk("status_short_cleared", 0, rd[ST_SHORT]);
		$display("short test done");

		for (int p = 0; p < 2; p++) begin
			ntc_code <= 8'h40;
			cyc(4);
			chk("ntc_at_trip", 0, supply_shutdown_command);
			ntc_code <= 8'h3F;
			cyc(4);
			chk("ntc_shutdown", 1, supply_shutdown_command);
			ntc_code <= 8'hC0;
			cyc(10);
			chk("shutdown_held", 1, supply_shutdown_command);
			if (p == 0) bpp_rst <= 1'b1;
			else uv <= 1'b1;
			cyc(8);
			chk("shutdown_cleared", 0, supply_shutdown_command);
			{bpp_rst, uv} <= 2'b00;
			cyc(8);
		end
		wb(1, OFS_STATUS, 32'h4);
		$display("connector temperature test done");

		for (int c = 1; c >= 0; c--) begin
			ccm_active <= c[0];
			@(posedge ref_clk);
			cycle_request <= 1'b1;
			@(posedge ref_clk);
			cycle_request <= 1'b0;
			@(posedge ref_clk);
			chk("sr_gate_off", c[0], sr_gate_off);
			@(posedge ref_clk);
			chk("primary_cycle_request", 1, primary_cycle_request);
		end
		wb(1, OFS_CTRL, 32'hA2);
		cyc(2);
		chk("fast_transient", 1, fast_transient);
		wb(1, OFS_CTRL, 32'h83);
		wait_for(0);
		rail_ok <= 1'b0;
		cyc(8);
		chk("rail_down_switch", 0, vconn_switch_on);
		rail_ok <= 1'b1;
		wb(1, OFS_CTRL, 32'h82);
		cyc(8);
		$display("regulation test done");

		vt = '{16'h1C1F, 16'h2710, 16'h07D0, 16'h0, 16'h0};
		it = '{8'h7F, 8'h80, 8'hC8, 8'h0, 8'h0};
		ar = 1'b0;
		wb(1, OFS_CTRL, 32'hC2);
		for (int k = 0; k < 5; k++) begin
			if (k > 2) begin
				lfsr_q = lfsr_next(lfsr_q);
				vt[k] = 16'(3000 + lfsr_q % 21000);
				lfsr_q = lfsr_next(lfsr_q);
				it[k] = lfsr_q[7:0];
			end
			ar = (it[k] >= IOUT_FULL_CODE) && (ar || vt[k] < 16'd3000);
			feed(vt[k], it[k]);
			cyc(4);
			chk("cc_regulation", it[k] >= IOUT_FULL_CODE, cc_regulation);
			chk("auto_restart", ar, auto_restart);
			chk("ripple_reduce", it[k] >= IOUT_FULL_CODE, ripple_reduce);
			cyc(UPD * 2 + 4);
			chk("output_sense_pin_report", quant(vt[k]), output_sense_pin_report);
			chk("iout_report", it[k], iout_report);
		end
		$display("telemetry test done");
		close_out();
	end
endmodule
`default_nettype wire
